// File: core/ocm_overrange_clock_out.sv
// Purpose: Over-range flag pins A-D with clock-out option on pins C and D
// Assumes: All inputs synchronous to clock; reference sampled as a level
// Notes:   Every pin output comes straight from a flip-flop

`timescale 1ns/10ps

module ocm_overrange_clock_out #(
    parameter int CHANNEL_COUNT = ocm_pkg::VARIANT_QUAD
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ocm_pkg::MAG_W-1:0] magnitude_a,
    input wire logic [ocm_pkg::MAG_W-1:0] magnitude_b,
    input wire logic [ocm_pkg::MAG_W-1:0] magnitude_c,
    input wire logic [ocm_pkg::MAG_W-1:0] magnitude_d,
    input wire logic [ocm_pkg::MAG_W-1:0] overrange_threshold,
    input wire logic [ocm_pkg::HOLD_W-1:0] overrange_hold_count,
    input wire logic ref_clock_diff,
    input wire logic ref_clock_single_ended,
    input wire logic ref_select_single_ended,
    input wire logic pll_enable,
    input wire logic power_down_pin,
    input wire logic [ocm_pkg::SEL_W-1:0] clock_out_select_straps,
    input wire logic serial_clock_override,
    input wire logic serial_clock_disable,
    input wire logic [ocm_pkg::SEL_W-1:0] serial_select_c,
    input wire logic [ocm_pkg::SEL_W-1:0] serial_select_d,
    output logic overrange_flag_a,
    output logic overrange_flag_b,
    output logic overrange_or_clock_c,
    output logic overrange_or_clock_d,
    output logic reference_clock_repeat_out
);

    logic [ocm_pkg::MAG_W-1:0] magnitude [ocm_pkg::CH_COUNT];
    logic [ocm_pkg::CH_COUNT-1:0] channel_present;
    logic [ocm_pkg::CH_COUNT-1:0] flag;
    logic ref_selected;
    logic clock_allowed;
    logic [ocm_pkg::SEL_W-1:0] select_c;
    logic [ocm_pkg::SEL_W-1:0] select_d;
    logic clock_mode_c;
    logic clock_mode_d;
    logic divided_ref_half;
    logic divided_ref_quarter;
    logic divided_ref_out_c;
    logic divided_ref_out_d;

    assign magnitude[ocm_pkg::CH_A] = magnitude_a;
    assign magnitude[ocm_pkg::CH_B] = magnitude_b;
    assign magnitude[ocm_pkg::CH_C] = magnitude_c;
    assign magnitude[ocm_pkg::CH_D] = magnitude_d;

    // ****************************************************************
    // Per-channel over-range flags
    // ****************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < ocm_pkg::CH_COUNT; ch = ch + 1) begin : g_channel
            // Channel exists only in variants wide enough to carry it
            assign channel_present[ch] = (ch < CHANNEL_COUNT);

            ocm_overrange_hold u_hold (
                .clock(clock),
                .rst(rst),
                .enable(channel_present[ch]),
                .magnitude(magnitude[ch]),
                .threshold(overrange_threshold),
                .hold_count(overrange_hold_count),
                .flag(flag[ch])
            );
        end
    endgenerate

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            overrange_flag_a <= 1'b0;
            overrange_flag_b <= 1'b0;
        end else begin
            overrange_flag_a <= flag[ocm_pkg::CH_A];
            overrange_flag_b <= flag[ocm_pkg::CH_B];
        end
    end

    // ****************************************************************
    // Reference repeat
    // ****************************************************************
    assign clock_allowed = pll_enable && !power_down_pin;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ref_selected <= 1'b0;
        end else if (ref_select_single_ended) begin
            ref_selected <= ref_clock_single_ended;
        end else begin
            ref_selected <= ref_clock_diff;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reference_clock_repeat_out <= 1'b0;
        end else begin
            reference_clock_repeat_out <= clock_allowed && ref_selected;
        end
    end

    ocm_ref_divider u_divider (
        .clock(clock),
        .rst(rst),
        .ref_level(ref_selected),
        .divided_ref_half(divided_ref_half),
        .divided_ref_quarter(divided_ref_quarter)
    );

    // ****************************************************************
    // Clock-out selection
    // ****************************************************************
    always_comb begin
        select_c = ocm_pkg::SEL_FLAG;
        select_d = ocm_pkg::SEL_FLAG;
        if (serial_clock_disable) begin
            select_c = ocm_pkg::SEL_FLAG;
            select_d = ocm_pkg::SEL_FLAG;
        end else if (serial_clock_override) begin
            select_c = serial_select_c;
            select_d = serial_select_d;
        end else begin
            select_c = clock_out_select_straps;
            if (clock_out_select_straps != ocm_pkg::SEL_FLAG) begin
                select_d = ocm_pkg::SEL_REPEAT;
            end
        end
    end

    assign clock_mode_c = clock_allowed && (select_c != ocm_pkg::SEL_FLAG);
    assign clock_mode_d = clock_mode_c && (select_d != ocm_pkg::SEL_FLAG);

    always_comb begin
        case (select_c)
            ocm_pkg::SEL_REPEAT: divided_ref_out_c = ref_selected;
            ocm_pkg::SEL_DIV2: divided_ref_out_c = divided_ref_half;
            ocm_pkg::SEL_DIV4: divided_ref_out_c = divided_ref_quarter;
            default: divided_ref_out_c = 1'b0;
        endcase
    end

    always_comb begin
        case (select_d)
            ocm_pkg::SEL_REPEAT: divided_ref_out_d = ref_selected;
            ocm_pkg::SEL_DIV2: divided_ref_out_d = divided_ref_half;
            ocm_pkg::SEL_DIV4: divided_ref_out_d = divided_ref_quarter;
            default: divided_ref_out_d = 1'b0;
        endcase
    end

    // ****************************************************************
    // Shared pins C and D
    // ****************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            overrange_or_clock_c <= 1'b0;
        end else if (clock_mode_c) begin
            overrange_or_clock_c <= divided_ref_out_c;
        end else begin
            overrange_or_clock_c <= flag[ocm_pkg::CH_C];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            overrange_or_clock_d <= 1'b0;
        end else if (clock_mode_d) begin
            overrange_or_clock_d <= divided_ref_out_d;
        end else begin
            overrange_or_clock_d <= flag[ocm_pkg::CH_D];
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_flag_pin_a: assert property (@(posedge clock) disable iff (rst)
        (magnitude_a > overrange_threshold) |=> ##1 overrange_flag_a)
        else $error("Flag A pin not raised two cycles after exceed");

    chk_flag_when_off: assert property (@(posedge clock) disable iff (rst)
        (serial_clock_disable || !clock_mode_c) |=> overrange_or_clock_c == $past(flag[2]))
        else $error("Pin C not carrying its flag");

    chk_variant_quiet: assert property (@(posedge clock) disable iff (rst)
        (CHANNEL_COUNT < ocm_pkg::VARIANT_QUAD && !clock_mode_d) |=> !overrange_or_clock_d)
        else $error("Pin D flag active in a narrow variant");

    // Two sampled cycles of clock permission, the first already out of reset
    sequence s_clock_settled;
        (!rst && clock_allowed) ##1 clock_allowed;
    endsequence

    // Pin D in a clock mode, taken from a given select
    sequence s_d_div2;
        clock_mode_d && select_d == ocm_pkg::SEL_DIV2;
    endsequence

    sequence s_d_div4;
        clock_mode_d && select_d == ocm_pkg::SEL_DIV4;
    endsequence

    chk_repeat_c: assert property (@(posedge clock) disable iff (rst)
        (clock_mode_c && select_c == ocm_pkg::SEL_REPEAT)
        |=> overrange_or_clock_c == $past(ref_selected))
        else $error("Pin C not repeating the reference");

    chk_div2_c: assert property (@(posedge clock) disable iff (rst)
        (clock_mode_c && select_c == ocm_pkg::SEL_DIV2)
        |=> overrange_or_clock_c == $past(divided_ref_half))
        else $error("Pin C not at half reference rate");

    chk_div4_c: assert property (@(posedge clock) disable iff (rst)
        (clock_mode_c && select_c == ocm_pkg::SEL_DIV4)
        |=> overrange_or_clock_c == $past(divided_ref_quarter))
        else $error("Pin C not at quarter reference rate");

    chk_d_serial_div2: assert property (@(posedge clock) disable iff (rst)
        s_d_div2 |=> overrange_or_clock_d == $past(divided_ref_half))
        else $error("Pin D not at half reference rate");

    chk_d_serial_div4: assert property (@(posedge clock) disable iff (rst)
        s_d_div4 |=> overrange_or_clock_d == $past(divided_ref_quarter))
        else $error("Pin D not at quarter reference rate");

    chk_d_strap_undivided: assert property (@(posedge clock) disable iff (rst)
        (!serial_clock_override && !serial_clock_disable && clock_mode_d)
        |=> overrange_or_clock_d == $past(ref_selected))
        else $error("Pin D divided from the straps alone");

    chk_b_absent: assert property (@(posedge clock) disable iff (rst)
        (CHANNEL_COUNT < ocm_pkg::VARIANT_DUAL) |=> !overrange_flag_b)
        else $error("Flag B active in a single variant");

    chk_no_pll_no_clock: assert property (@(posedge clock) disable iff (rst)
        !pll_enable
        |=> overrange_or_clock_c == $past(flag[2]) && overrange_or_clock_d == $past(flag[3]))
        else $error("Clock out on pins C or D with PLL disabled");

    chk_strap_power_up: assert property (@(posedge clock) disable iff (rst)
        (clock_allowed && !serial_clock_override && !serial_clock_disable
            && clock_out_select_straps == ocm_pkg::SEL_DIV4)
        |=> overrange_or_clock_c == $past(divided_ref_quarter)
            && overrange_or_clock_d == $past(ref_selected))
        else $error("Strap clock modes not applied");

    chk_d_needs_c: assert property (@(posedge clock) disable iff (rst)
        !clock_mode_c |=> overrange_or_clock_d == $past(flag[3]))
        else $error("Pin D clock without pin C clock");

    chk_power_down_stop: assert property (@(posedge clock) disable iff (rst)
        power_down_pin |=> !reference_clock_repeat_out)
        else $error("Repeat output running in power-down");

    chk_ref_source: assert property (@(posedge clock) disable iff (rst)
        s_clock_settled |=> reference_clock_repeat_out ==
            $past(ref_select_single_ended ? ref_clock_single_ended : ref_clock_diff, 2))
        else $error("Repeat output not from the selected reference");

endmodule // ocm_overrange_clock_out

// File: core/ocm_overrange_hold.sv
// Purpose: One channel's over-range flag with minimum high time
// Assumes: Magnitude and threshold are unsigned and synchronous to clock
// Notes:   Flag stays high for hold_count+1 cycles after the last exceeding sample

`timescale 1ns/10ps

module ocm_overrange_hold (
    input wire logic clock,
    input wire logic rst,
    input wire logic enable,
    input wire logic [ocm_pkg::MAG_W-1:0] magnitude,
    input wire logic [ocm_pkg::MAG_W-1:0] threshold,
    input wire logic [ocm_pkg::HOLD_W-1:0] hold_count,
    output logic flag
);

    logic [ocm_pkg::HOLD_W-1:0] remain;
    logic exceed;

    assign exceed = enable && (magnitude > threshold);

    // ****************************************************************
    // Flag and hold counter
    // ****************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flag <= 1'b0;
            remain <= ocm_pkg::HOLD_RESET;
        end else if (!enable) begin
            flag <= 1'b0;
            remain <= ocm_pkg::HOLD_RESET;
        end else if (exceed) begin
            flag <= 1'b1;
            remain <= hold_count;
        end else if (remain != ocm_pkg::HOLD_RESET) begin
            flag <= 1'b1;
            remain <= remain - 4'h1;
        end else begin
            flag <= 1'b0;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_flag_on_exceed: assert property (@(posedge clock) disable iff (rst)
        exceed |=> flag && remain == $past(hold_count))
        else $error("Flag not raised with full hold after exceed");

    chk_flag_min_hold: assert property (@(posedge clock) disable iff (rst)
        (enable && flag && remain != ocm_pkg::HOLD_RESET) ##1 enable |-> flag)
        else $error("Flag dropped before hold time ended");

    chk_flag_cause: assert property (@(posedge clock) disable iff (rst)
        $rose(flag) |-> $past(exceed))
        else $error("Flag rose without an exceeding sample");

endmodule // ocm_overrange_hold

// File: core/ocm_pkg.sv
// Purpose: Shared constants for the over-range flag and clock-out pin logic
// Assumes: One 40 MHz system clock; every input is synchronous to it
// Notes:   Select encodings apply to both the straps and the serial override

// ****************************************************************
// Package
// ****************************************************************
package ocm_pkg;

    // Sample magnitude, hold count and select widths
    localparam int MAG_W = 12;
    localparam int HOLD_W = 4;
    localparam int SEL_W = 2;

    // Channel indices
    localparam int CH_A = 0;
    localparam int CH_B = 1;
    localparam int CH_C = 2;
    localparam int CH_D = 3;
    localparam int CH_COUNT = 4;

    // Variant channel counts
    localparam int VARIANT_SINGLE = 1;
    localparam int VARIANT_DUAL = 2;
    localparam int VARIANT_QUAD = 4;

    // Clock-out select encodings
    localparam logic [SEL_W-1:0] SEL_FLAG = 2'h0;
    localparam logic [SEL_W-1:0] SEL_REPEAT = 2'h1;
    localparam logic [SEL_W-1:0] SEL_DIV2 = 2'h2;
    localparam logic [SEL_W-1:0] SEL_DIV4 = 2'h3;

    // Reset values
    localparam logic [HOLD_W-1:0] HOLD_RESET = 4'h0;
    localparam logic [1:0] DIV_RESET = 2'h0;

    typedef enum logic [1:0] {
        OCM_SRC_FLAG,
        OCM_SRC_REPEAT,
        OCM_SRC_DIV2,
        OCM_SRC_DIV4
    } ocm_src_t;

endpackage

// File: core/ocm_ref_divider.sv
// Purpose: Free-running divide-by-2 and divide-by-4 of the repeated reference
// Assumes: Reference level is registered and slower than half the clock
// Notes:   Counts rising edges of the reference, so duty cycle is near even

`timescale 1ns/10ps

module ocm_ref_divider (
    input wire logic clock,
    input wire logic rst,
    input wire logic ref_level,
    output logic divided_ref_half,
    output logic divided_ref_quarter
);

    logic ref_prev;
    logic [1:0] count;
    logic ref_rise;

    assign ref_rise = ref_level && !ref_prev;
    assign divided_ref_half = count[0];
    assign divided_ref_quarter = count[1];

    // ****************************************************************
    // Edge counter
    // ****************************************************************
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ref_prev <= 1'b0;
        end else begin
            ref_prev <= ref_level;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count <= ocm_pkg::DIV_RESET;
        end else if (ref_rise) begin
            count <= count + 2'h1;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_half_toggle: assert property (@(posedge clock) disable iff (rst)
        ref_rise |=> divided_ref_half != $past(divided_ref_half))
        else $error("Divide-by-2 did not toggle on reference edge");

    chk_quarter_toggle: assert property (@(posedge clock) disable iff (rst)
        (ref_rise && divided_ref_half) |=> divided_ref_quarter != $past(divided_ref_quarter))
        else $error("Divide-by-4 did not toggle after two edges");

    chk_still_between: assert property (@(posedge clock) disable iff (rst)
        !ref_rise |=> $stable(count))
        else $error("Divider moved without a reference edge");

endmodule // ocm_ref_divider

// File: testbench/ocm_far_side_model.sv
// Purpose: Far-side reference oscillators for the clock-out block
// Assumes: References run free and far slower than the system clock
// Notes:   Edges are launched just after the system clock edge

`timescale 1ns/10ps

// ****************************************************************
// Reference source
// ****************************************************************
module ocm_far_side_model #(
    parameter int DIFF_HALF = 4,
    parameter int SE_HALF = 8
) (
    input wire logic clock,
    output logic ref_diff,
    output logic ref_single
);
    int cnt = 0;

    initial begin
        ref_diff = 1'h0;
        ref_single = 1'h0;
    end

    // Two rates so the chosen source can be told apart
    always @(posedge clock) begin
        cnt <= cnt + 1;
        if ((cnt + 1) % DIFF_HALF == 0) begin
            ref_diff <= !ref_diff;
        end
        if ((cnt + 1) % SE_HALF == 0) begin
            ref_single <= !ref_single;
        end
    end
endmodule // ocm_far_side_model

// File: testbench/tb_top.sv
// Purpose: Self-checking bench for the over-range and clock-out pins
// Assumes: Differential reference period 8 cycles, single-ended 16
// Notes:   Clock rows first, then reset and flag corner cases

`timescale 1ns/10ps

// ****************************************************************
// Bench
// ****************************************************************
module tb_top;
    typedef struct {
        logic pl, pw, rs, o, d;
        logic [1:0] st, sc, sd;
        int pin;
        logic [7:0] per;
    } ocm_tb_row_t;

    logic clock = 1'h0;
    logic rst = 1'h1;
    logic [ocm_pkg::MAG_W-1:0] mag [4] = '{12'h0, 12'h0, 12'h0, 12'h0};
    logic [ocm_pkg::MAG_W-1:0] thr = 12'h7ff;
    logic [ocm_pkg::HOLD_W-1:0] hold = 4'h0;
    logic ref_d, ref_s;
    logic rsel = 1'h0, pll = 1'h1, pd = 1'h0, ov = 1'h0, dis = 1'h0;
    logic [1:0] st = 2'h0, sc = 2'h0, sd = 2'h0;
    wire [4:0] pins, pins1;
    int err_count = 0;
    int checks = 0;
    logic [7:0] n;
    ocm_tb_row_t rows [20] = '{
        '{1, 0, 0, 0, 0, 1, 0, 0, 2, 8'h08},
        '{1, 0, 0, 0, 0, 2, 0, 0, 2, 8'h10},
        '{1, 0, 0, 0, 0, 3, 0, 0, 2, 8'h20},
        '{1, 0, 0, 0, 0, 1, 0, 0, 3, 8'h08},
        '{1, 0, 0, 0, 0, 2, 0, 0, 3, 8'h08},
        '{1, 0, 0, 0, 0, 3, 0, 0, 3, 8'h08},
        '{1, 0, 0, 1, 0, 0, 3, 2, 3, 8'h10},
        '{1, 0, 0, 1, 0, 0, 1, 3, 3, 8'h20},
        '{1, 0, 0, 1, 0, 0, 2, 2, 2, 8'h10},
        '{1, 0, 0, 1, 0, 0, 0, 1, 3, 8'h00},
        '{1, 0, 0, 1, 1, 1, 1, 1, 2, 8'h00},
        '{1, 0, 0, 1, 1, 1, 1, 1, 3, 8'h00},
        '{0, 0, 0, 0, 0, 1, 0, 0, 2, 8'h00},
        '{0, 0, 0, 0, 0, 1, 0, 0, 3, 8'h00},
        '{0, 0, 0, 0, 0, 1, 0, 0, 4, 8'h00},
        '{1, 1, 0, 0, 0, 1, 0, 0, 2, 8'h00},
        '{1, 1, 0, 0, 0, 1, 0, 0, 3, 8'h00},
        '{1, 1, 0, 0, 0, 0, 0, 0, 4, 8'h00},
        '{1, 0, 1, 0, 0, 1, 0, 0, 2, 8'h10},
        '{1, 0, 1, 0, 0, 0, 0, 0, 4, 8'h10}
    };

    initial begin
        forever #12.5 clock = !clock;
    end

    ocm_far_side_model far (.clock(clock), .ref_diff(ref_d), .ref_single(ref_s));

    ocm_overrange_clock_out dut (
        .clock(clock), .rst(rst), .magnitude_a(mag[0]), .magnitude_b(mag[1]),
        .magnitude_c(mag[2]), .magnitude_d(mag[3]), .overrange_threshold(thr),
        .overrange_hold_count(hold), .ref_clock_diff(ref_d), .ref_clock_single_ended(ref_s),
        .ref_select_single_ended(rsel), .pll_enable(pll), .power_down_pin(pd),
        .clock_out_select_straps(st), .serial_clock_override(ov), .serial_clock_disable(dis),
        .serial_select_c(sc), .serial_select_d(sd), .overrange_flag_a(pins[0]),
        .overrange_flag_b(pins[1]), .overrange_or_clock_c(pins[2]),
        .overrange_or_clock_d(pins[3]), .reference_clock_repeat_out(pins[4])
    );

    ocm_overrange_clock_out #(.CHANNEL_COUNT(ocm_pkg::VARIANT_SINGLE)) dut_single (
        .clock(clock), .rst(rst), .magnitude_a(mag[0]), .magnitude_b(mag[1]),
        .magnitude_c(mag[2]), .magnitude_d(mag[3]), .overrange_threshold(thr),
        .overrange_hold_count(hold), .ref_clock_diff(ref_d), .ref_clock_single_ended(ref_s),
        .ref_select_single_ended(rsel), .pll_enable(pll), .power_down_pin(pd),
        .clock_out_select_straps(st), .serial_clock_override(ov), .serial_clock_disable(dis),
        .serial_select_c(sc), .serial_select_d(sd), .overrange_flag_a(pins1[0]),
        .overrange_flag_b(pins1[1]), .overrange_or_clock_c(pins1[2]),
        .overrange_or_clock_d(pins1[3]), .reference_clock_repeat_out(pins1[4])
    );

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %0d, seen %0d", name, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Count high cycles of a flag pin after len exceeding samples
    task automatic flag_case(input int ch, input logic [11:0] m, input int len);
        n = 8'h0;
        @(posedge clock);
        mag[ch] <= m;
        for (int k = 0; k < 30; k++) begin
            @(negedge clock);
            if (pins[ch] === 1'h1) n++;
            @(posedge clock);
            if (k + 1 == len) mag[ch] <= 12'h0;
        end
    endtask

    // Cycles between two rising edges, 0 when the pin does not toggle
    task automatic period(input int p);
        int t;
        logic prev;
        t = 0;
        repeat (2) begin
            t = 0;
            do begin
                prev = pins[p];
                @(negedge clock);
                t++;
            end while (!(prev === 1'h0 && pins[p] === 1'h1) && t < 80);
        end
        n = (t < 80) ? t[7:0] : 8'h0;
    endtask

    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'h0;
        foreach (rows[i]) begin
            @(posedge clock);
            {pll, pd, rsel, ov, dis} <= {rows[i].pl, rows[i].pw, rows[i].rs, rows[i].o, rows[i].d};
            {st, sc, sd} <= {rows[i].st, rows[i].sc, rows[i].sd};
            repeat (4) @(negedge clock);
            period(rows[i].pin);
            check($sformatf("row %0d", i), rows[i].per, n);
        end
        $display("test clock rows done");
        @(posedge clock);
        {pll, pd, rsel, ov, dis, st} <= {5'h10, 2'h1};
        rst <= 1'h1;
        repeat (3) @(negedge clock);
        check("pins in reset", 8'h0, {3'h0, pins});
        @(posedge clock);
        rst <= 1'h0;
        st <= 2'h0;
        $display("test reset done");
        for (int ch = 0; ch < 4; ch++) begin
            hold <= 4'h5;
            flag_case(ch, 12'h800, 1);
            check("flag hold", 8'h06, n);
            flag_case(ch, 12'h7ff, 1);
            check("flag at threshold", 8'h00, n);
            hold <= 4'h0;
            flag_case(ch, 12'h801, 3);
            check("flag retrigger", 8'h03, n);
            hold <= 4'hf;
            flag_case(ch, 12'hfff, 2);
            check("flag max hold", 8'h11, n);
        end
        $display("test flags done");
        hold <= 4'h2;
        {st, ov, dis} <= {2'h1, 2'h3};
        flag_case(2, 12'hfff, 1);
        check("flag c while disabled", 8'h03, n);
        $display("test serial disable done");
        @(posedge clock);
        st <= 2'h0;
        mag <= '{12'hfff, 12'hfff, 12'hfff, 12'hfff};
        repeat (4) @(negedge clock);
        check("single variant pins", 8'h01, {4'h0, pins1[3:0]});
        check("quad variant pins", 8'h0f, {4'h0, pins[3:0]});
        $display("test variants done");
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        final_report();
    end
endmodule // tb_top
